// [rtl/cdj_pkg.sv]
package cdj_pkg;
  localparam int         ADDR_W         = 4;
  localparam logic [3:0] REG_CMD        = 4'h0;
  localparam logic [3:0] REG_CFG        = 4'h1;
  localparam logic [3:0] REG_TX_HEAD    = 4'h2;
  localparam logic [3:0] REG_RX_HEAD    = 4'h3;
  localparam logic [3:0] REG_SLOT_MAP   = 4'h4;
  localparam logic [3:0] REG_STATUS     = 4'h5;
  localparam logic [1:0] OP_ACTIVATE    = 2'h1;
  localparam logic [1:0] OP_DEACTIVATE  = 2'h2;
  localparam logic [1:0] OP_JUMP        = 2'h3;
  localparam int         CMD_OP_LSB     = 0;
  localparam int         CMD_DIR_BIT    = 2;
  localparam int         CFG_W          = 5;
  localparam int         CFG_TRI_BIT    = 0;
  localparam int         CFG_EXT_BIT    = 1;
  localparam int         CFG_CONCAT_BIT = 2;
  localparam int         CFG_TX_TR_BIT  = 3;
  localparam int         CFG_RX_TR_BIT  = 4;
  localparam logic [4:0] CFG_RST        = 5'h00;
  localparam logic [31:0] HEAD_RST      = 32'h0000_0000;
  localparam logic [31:0] MAP_RST       = 32'h0000_0000;
  localparam int         FRAME_BITS_DEF = 256;
  localparam int         CNT_W          = 10;
  localparam int         DIR_TX         = 0;
  localparam int         DIR_RX         = 1;
  typedef enum logic [2:0] {
    ST_IDLE, ST_HEAD, ST_DESC, ST_ALIGN, ST_SLOT, ST_RUN, ST_JWAIT
  } cdj_state_t;
endpackage : cdj_pkg

// [rtl/cdj_fly_if.sv]
`timescale 1ns/10ps
interface cdj_fly_if #(parameter int CW = 10);
  logic          tick;
  logic          sync;
  logic          concat;
  logic          int_bof;
  logic          ext_bof;
  logic          upd;
  logic          locked;
  logic [CW-1:0] cnt;
  modport timer (input tick, sync, concat,
                 output int_bof, ext_bof, upd, locked, cnt);
  modport user  (output tick, sync, concat,
                 input int_bof, ext_bof, upd, locked, cnt);
endinterface : cdj_fly_if

// [rtl/cdj_flywheel.sv]
`timescale 1ns/10ps
module cdj_flywheel #(
  parameter int FRAME_BITS = 256,
  parameter int CW         = 10
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  cdj_fly_if.timer fly
);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          ibof_reg;
  logic          ibof_next;
  logic          ebof_reg;
  logic          ebof_next;
  logic          upd_reg;
  logic          upd_next;
  logic          lock_reg;
  logic          lock_next;

  always_comb begin
    cnt_next  = cnt_reg;
    lock_next = lock_reg;
    ibof_next = 1'b0;
    ebof_next = 1'b0;
    upd_next  = 1'b0;
    if (fly.tick) begin
      upd_next = 1'b1;
      if (fly.sync) begin
        // Any sync realigns the count, in every mode
        cnt_next  = '0;
        ibof_next = 1'b1;
        ebof_next = 1'b1;
        lock_next = 1'b1;
      end else if (lock_reg && !fly.concat) begin
        if (cnt_reg == CW'(FRAME_BITS - 1)) begin
          cnt_next  = '0;
          ibof_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end else if (fly.concat && cnt_reg != '1) begin
        // No wrap: a missing sync saturates instead of faking a frame
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg  <= '0;
      ibof_reg <= 1'b0;
      ebof_reg <= 1'b0;
      upd_reg  <= 1'b0;
      lock_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      ibof_reg <= ibof_next;
      ebof_reg <= ebof_next;
      upd_reg  <= upd_next;
      lock_reg <= lock_next;
    end
  end

  assign fly.cnt     = cnt_reg;
  assign fly.int_bof = ibof_reg;
  assign fly.ext_bof = ebof_reg;
  assign fly.upd     = upd_reg;
  assign fly.locked  = lock_reg;
endmodule : cdj_flywheel

// [rtl/cdj_top.sv]
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module cdj_top #(
  parameter int FRAME_BITS = cdj_pkg::FRAME_BITS_DEF
) (
  input  wire logic               clock_i,
  input  wire logic               nrst_i,
  input  wire logic [3:0]         reg_addr_i,
  input  wire logic [31:0]        reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic      [31:0]        reg_rdata_o,
  input  wire logic               tx_clk_i,
  input  wire logic               rx_clk_i,
  input  wire logic               tx_frame_sync_i,
  input  wire logic               rx_frame_sync_i,
  input  wire logic               tx_bit_i,
  input  wire logic               tx_msg_done_i,
  output logic                    tx_serial_data_o,
  output logic                    tx_serial_data_oe_o,
  output logic      [1:0]         proc_en_o,
  output logic      [1:0]         dma_en_o,
  output logic      [1:0]         abort_o,
  output logic      [1:0]         mem_req_o,
  output logic      [1:0]         mem_desc_o,
  output logic      [1:0][31:0]   mem_addr_o,
  input  wire logic [1:0]         mem_ack_i,
  input  wire logic [1:0]         mem_owner_i,
  input  wire logic [1:0][31:0]   mem_rdata_i,
  output logic                    service_ack_descriptor_o,
  output logic                    service_ack_descriptor_dir_o,
  output logic      [1:0]         service_ack_descriptor_op_o
);
  localparam int CW = cdj_pkg::CNT_W;

  // Lowest assigned slot; slot zero defers to the next assigned one
  function automatic logic [6:0] cdj_first_slot(input logic [31:0] map);
    logic [6:0] res;
    logic       found;
    res   = 7'h00;
    found = 1'b0;
    for (int i = 31; i >= 1; i--) begin
      if (map[i]) begin
        res   = 7'(i);
        found = 1'b1;
      end
    end
    if (!found || !map[0]) begin
      cdj_first_slot = res;
    end else begin
      cdj_first_slot = res;
    end
  endfunction : cdj_first_slot

  function automatic logic cdj_active(input cdj_pkg::cdj_state_t s);
    cdj_active = (s == cdj_pkg::ST_ALIGN) || (s == cdj_pkg::ST_SLOT) ||
                 (s == cdj_pkg::ST_RUN) || (s == cdj_pkg::ST_JWAIT);
  endfunction : cdj_active

  // Pin synchronisers: {rx_sync, tx_sync, rx_clk, tx_clk}
  logic [3:0]  pin_a_reg;
  logic [3:0]  pin_b_reg;
  logic [1:0]  clk_prev_reg;
  logic [1:0]  sync_prev_reg;
  logic [1:0]  sync_prev_next;
  logic [1:0]  tick;
  logic [1:0]  sync_evt;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_a_reg     <= 4'h0;
      pin_b_reg     <= 4'h0;
      clk_prev_reg  <= 2'h0;
      sync_prev_reg <= 2'h0;
    end else begin
      pin_a_reg     <= {rx_frame_sync_i, tx_frame_sync_i, rx_clk_i, tx_clk_i};
      pin_b_reg     <= pin_a_reg;
      clk_prev_reg  <= pin_b_reg[1:0];
      sync_prev_reg <= sync_prev_next;
    end
  end

  always_comb begin
    tick           = pin_b_reg[1:0] & ~clk_prev_reg;
    sync_evt       = tick & pin_b_reg[3:2] & ~sync_prev_reg;
    sync_prev_next = sync_prev_reg;
    for (int d = 0; d < 2; d++) begin
      if (tick[d]) begin
        sync_prev_next[d] = pin_b_reg[2+d];
      end
    end
  end

  // Frame timers, one per direction
  cdj_fly_if #(.CW(CW)) fly_tx ();
  cdj_fly_if #(.CW(CW)) fly_rx ();

  // Register file
  logic [cdj_pkg::CFG_W-1:0] cfg_reg;
  logic [cdj_pkg::CFG_W-1:0] cfg_next;
  logic [1:0][31:0]          head_reg;
  logic [1:0][31:0]          head_next;
  logic [31:0]               map_reg;
  logic [31:0]               map_next;
  logic [31:0]               rdata_reg;
  logic [31:0]               rdata_next;
  logic                      cmd_wr;
  logic [1:0]                cmd_op;
  logic                      cmd_dir;
  logic                      concat;
  logic                      ext_align;

  cdj_pkg::cdj_state_t st_reg  [2];
  cdj_pkg::cdj_state_t st_next [2];

  assign cmd_wr    = reg_wr_i && (reg_addr_i == cdj_pkg::REG_CMD);
  assign cmd_op    = reg_wdata_i[cdj_pkg::CMD_OP_LSB +: 2];
  assign cmd_dir   = reg_wdata_i[cdj_pkg::CMD_DIR_BIT];
  assign concat    = cfg_reg[cdj_pkg::CFG_CONCAT_BIT];
  assign ext_align = cfg_reg[cdj_pkg::CFG_EXT_BIT];

  always_comb begin
    cfg_next   = cfg_reg;
    head_next  = head_reg;
    map_next   = map_reg;
    rdata_next = 32'h0000_0000;
    if (reg_wr_i) begin
      case (reg_addr_i)
        cdj_pkg::REG_CFG:      cfg_next = reg_wdata_i[cdj_pkg::CFG_W-1:0];
        cdj_pkg::REG_TX_HEAD:  head_next[cdj_pkg::DIR_TX] = reg_wdata_i;
        cdj_pkg::REG_RX_HEAD:  head_next[cdj_pkg::DIR_RX] = reg_wdata_i;
        cdj_pkg::REG_SLOT_MAP: map_next = reg_wdata_i;
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        cdj_pkg::REG_CFG:      rdata_next = {27'h000_0000, cfg_reg};
        cdj_pkg::REG_TX_HEAD:  rdata_next = head_reg[cdj_pkg::DIR_TX];
        cdj_pkg::REG_RX_HEAD:  rdata_next = head_reg[cdj_pkg::DIR_RX];
        cdj_pkg::REG_SLOT_MAP: rdata_next = map_reg;
        cdj_pkg::REG_STATUS:   rdata_next = {24'h00_0000, fly_rx.locked,
                                 fly_tx.locked, 3'(st_reg[1]),
                                 3'(st_reg[0])};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_reg   <= cdj_pkg::CFG_RST;
      head_reg  <= {cdj_pkg::HEAD_RST, cdj_pkg::HEAD_RST};
      map_reg   <= cdj_pkg::MAP_RST;
      rdata_reg <= 32'h0000_0000;
    end else begin
      cfg_reg   <= cfg_next;
      head_reg  <= head_next;
      map_reg   <= map_next;
      rdata_reg <= rdata_next;
    end
  end

  assign fly_tx.tick   = tick[cdj_pkg::DIR_TX];
  assign fly_tx.sync   = sync_evt[cdj_pkg::DIR_TX];
  assign fly_tx.concat = concat;
  assign fly_rx.tick   = tick[cdj_pkg::DIR_RX];
  assign fly_rx.sync   = sync_evt[cdj_pkg::DIR_RX];
  assign fly_rx.concat = concat;

  cdj_flywheel #(.FRAME_BITS(FRAME_BITS), .CW(CW)) u_fly_tx (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .fly     (fly_tx)
  );
  cdj_flywheel #(.FRAME_BITS(FRAME_BITS), .CW(CW)) u_fly_rx (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .fly     (fly_rx)
  );

  logic [1:0]    frame_evt;
  logic [1:0]    slot_hit;
  logic [6:0]    first_slot;
  logic [1:0]    transp;

  always_comb begin
    first_slot = cdj_first_slot(map_reg);
    transp = {cfg_reg[cdj_pkg::CFG_RX_TR_BIT], cfg_reg[cdj_pkg::CFG_TX_TR_BIT]};
    // Concatenated mode has no flywheel frame, so pins decide alone
    frame_evt[0] = (concat || ext_align) ? fly_tx.ext_bof
                                         : fly_tx.int_bof;
    frame_evt[1] = (concat || ext_align) ? fly_rx.ext_bof
                                         : fly_rx.int_bof;
    slot_hit[0]  = fly_tx.upd && (fly_tx.cnt[2:0] == 3'h0) &&
                   (fly_tx.cnt[CW-1:3] == first_slot);
    slot_hit[1]  = fly_rx.upd && (fly_rx.cnt[2:0] == 3'h0) &&
                   (fly_rx.cnt[CW-1:3] == first_slot);
  end

  // Direction state machines
  logic [1:0]       jmp_reg;
  logic [1:0]       jmp_next;
  logic [1:0][1:0]  reqop_reg;
  logic [1:0][1:0]  reqop_next;
  logic [1:0][31:0] ptr_reg;
  logic [1:0][31:0] ptr_next;
  logic [1:0]       ack_set;
  logic [1:0][1:0]  ack_set_op;
  logic [1:0]       abort_next;
  logic [1:0]       proc_next;
  logic [1:0]       dma_next;
  logic [1:0]       req_next;
  logic [1:0]       desc_next;
  logic [1:0][31:0] addr_next;

  always_comb begin
    logic req;
    req = 1'b0;
    for (int d = 0; d < 2; d++) begin
      req           = cmd_wr && (cmd_dir == 1'(d));
      st_next[d]    = st_reg[d];
      jmp_next[d]   = jmp_reg[d];
      reqop_next[d] = reqop_reg[d];
      ptr_next[d]   = ptr_reg[d];
      ack_set[d]    = 1'b0;
      ack_set_op[d] = cmd_pkg_op_none();
      abort_next[d] = 1'b0;
      if (req && cmd_op == cdj_pkg::OP_DEACTIVATE) begin
        // Cuts off at once, even mid-fetch or mid-jump
        abort_next[d] = (st_reg[d] != cdj_pkg::ST_IDLE);
        st_next[d]    = cdj_pkg::ST_IDLE;
        jmp_next[d]   = 1'b0;
        ack_set[d]    = 1'b1;
        ack_set_op[d] = cdj_pkg::OP_DEACTIVATE;
      end else if (req && (cmd_op == cdj_pkg::OP_ACTIVATE ||
                   (cmd_op == cdj_pkg::OP_JUMP &&
                    (d == cdj_pkg::DIR_RX ||
                     st_reg[d] == cdj_pkg::ST_IDLE)))) begin
        abort_next[d] = (st_reg[d] != cdj_pkg::ST_IDLE);
        st_next[d]    = cdj_pkg::ST_HEAD;
        jmp_next[d]   = 1'b0;
        reqop_next[d] = cmd_op;
      end else if (req && cmd_op == cdj_pkg::OP_JUMP) begin
        // Jump on transmit outside RUN and IDLE is ignored
        if (st_reg[d] == cdj_pkg::ST_RUN) begin
          st_next[d] = cdj_pkg::ST_JWAIT;
        end
      end else begin
        case (st_reg[d])
          cdj_pkg::ST_HEAD: begin
            if (mem_ack_i[d]) begin
              ptr_next[d] = mem_rdata_i[d];
              st_next[d]  = cdj_pkg::ST_DESC;
            end
          end
          cdj_pkg::ST_DESC: begin
            if (mem_ack_i[d]) begin
              if (!mem_owner_i[d]) begin
                st_next[d] = cdj_pkg::ST_IDLE;
              end else if (jmp_reg[d] || !transp[d]) begin
                st_next[d] = cdj_pkg::ST_RUN;
              end else begin
                st_next[d] = cdj_pkg::ST_ALIGN;
              end
              ack_set[d]    = !jmp_reg[d];
              ack_set_op[d] = reqop_reg[d];
              jmp_next[d]   = 1'b0;
            end
          end
          cdj_pkg::ST_ALIGN: begin
            if (frame_evt[d]) begin
              st_next[d] = cdj_pkg::ST_SLOT;
            end
          end
          cdj_pkg::ST_SLOT: begin
            if (slot_hit[d]) begin
              st_next[d] = cdj_pkg::ST_RUN;
            end
          end
          cdj_pkg::ST_JWAIT: begin
            if (d == cdj_pkg::DIR_TX && tx_msg_done_i) begin
              ack_set[d]    = 1'b1;
              ack_set_op[d] = cdj_pkg::OP_JUMP;
              jmp_next[d]   = 1'b1;
              st_next[d]    = cdj_pkg::ST_HEAD;
            end
          end
          default: ;
        endcase
      end
      req_next[d]  = (st_next[d] == cdj_pkg::ST_HEAD) ||
                     (st_next[d] == cdj_pkg::ST_DESC);
      desc_next[d] = (st_next[d] == cdj_pkg::ST_DESC);
      addr_next[d] = desc_next[d] ? ptr_next[d] : head_reg[d];
      // A transmit jump keeps the bit processor running across the fetch
      proc_next[d] = cdj_active(st_next[d]) ||
                     (jmp_next[d] && req_next[d]);
      dma_next[d]  = (st_next[d] == cdj_pkg::ST_RUN) ||
                     (st_next[d] == cdj_pkg::ST_JWAIT) ||
                     (jmp_next[d] && req_next[d]);
    end
  end

  function automatic logic [1:0] cmd_pkg_op_none();
    cmd_pkg_op_none = cdj_pkg::OP_ACTIVATE;
  endfunction : cmd_pkg_op_none

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int d = 0; d < 2; d++) begin
        st_reg[d] <= cdj_pkg::ST_IDLE;
      end
      jmp_reg    <= 2'h0;
      reqop_reg  <= 4'h0;
      ptr_reg    <= 64'h0000_0000_0000_0000;
      abort_o    <= 2'h0;
      proc_en_o  <= 2'h0;
      dma_en_o   <= 2'h0;
      mem_req_o  <= 2'h0;
      mem_desc_o <= 2'h0;
      mem_addr_o <= 64'h0000_0000_0000_0000;
    end else begin
      for (int d = 0; d < 2; d++) begin
        st_reg[d] <= st_next[d];
      end
      jmp_reg    <= jmp_next;
      reqop_reg  <= reqop_next;
      ptr_reg    <= ptr_next;
      abort_o    <= abort_next;
      proc_en_o  <= proc_next;
      dma_en_o   <= dma_next;
      mem_req_o  <= req_next;
      mem_desc_o <= desc_next;
      mem_addr_o <= addr_next;
    end
  end

  // Acknowledge queue: one descriptor a cycle, transmit first
  logic [1:0]      pend_reg;
  logic [1:0]      pend_next;
  logic [1:0][1:0] pop_reg;
  logic [1:0][1:0] pop_next;
  logic            service_ack_descriptor_next;
  logic            sdir_next;
  logic [1:0]      sop_next;
  logic [1:0]      sent;
  logic            txd_next;
  logic            txoe_next;

  always_comb begin
    sent      = pend_reg[0] ? 2'b01 : {pend_reg[1], 1'b0};
    service_ack_descriptor_next = |pend_reg;
    sdir_next = !pend_reg[0];
    sop_next  = pend_reg[0] ? pop_reg[0] : pop_reg[1];
    for (int d = 0; d < 2; d++) begin
      // A new ack in the cycle of the send is kept
      pend_next[d] = ack_set[d] || (pend_reg[d] && !sent[d]);
      pop_next[d]  = ack_set[d] ? ack_set_op[d] : pop_reg[d];
    end
    txd_next  = dma_next[0] ? tx_bit_i : 1'b1;
    txoe_next = proc_next[0] || !cfg_next[cdj_pkg::CFG_TRI_BIT];
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_reg                 <= 2'h0;
      pop_reg                  <= 4'h0;
      service_ack_descriptor_o <= 1'b0;
      service_ack_descriptor_dir_o               <= 1'b0;
      service_ack_descriptor_op_o                <= 2'h0;
      tx_serial_data_o         <= 1'b1;
      tx_serial_data_oe_o      <= 1'b0;
    end else begin
      pend_reg                 <= pend_next;
      pop_reg                  <= pop_next;
      service_ack_descriptor_o <= service_ack_descriptor_next;
      service_ack_descriptor_dir_o               <= sdir_next;
      service_ack_descriptor_op_o                <= sop_next;
      tx_serial_data_o         <= txd_next;
      tx_serial_data_oe_o      <= txoe_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  AST_DEACT_ACK: assert property (
    cmd_wr && cmd_op == cdj_pkg::OP_DEACTIVATE |->
      ##[2:3] (service_ack_descriptor_o &&
               service_ack_descriptor_op_o == cdj_pkg::OP_DEACTIVATE &&
               service_ack_descriptor_dir_o == $past(cmd_dir, 2)))
    else $error("deactivate not acknowledged");
  AST_TX_STOP: assert property (
    cmd_wr && cmd_op == cdj_pkg::OP_DEACTIVATE && !cmd_dir |=>
      !proc_en_o[0] && !dma_en_o[0] && !mem_req_o[0])
    else $error("transmit kept running after deactivate");
  AST_RX_STOP: assert property (
    cmd_wr && cmd_op == cdj_pkg::OP_DEACTIVATE && cmd_dir |=>
      !proc_en_o[1] && !dma_en_o[1] && !mem_req_o[1])
    else $error("receive kept running after deactivate");
  // The pin floats during reset, whatever the select says
  AST_TX_IDLE_PIN: assert property (
    !proc_en_o[0] && $past(nrst_i) |-> (tx_serial_data_o &&
      tx_serial_data_oe_o == !cfg_reg[cdj_pkg::CFG_TRI_BIT]))
    else $error("stopped transmit pin wrong");
  AST_SUSPEND: assert property (
    st_reg[1] == cdj_pkg::ST_IDLE && !(cmd_wr && cmd_dir) |=>
      st_reg[1] == cdj_pkg::ST_IDLE && ($stable(cfg_reg) || $past(reg_wr_i)))
    else $error("suspended receive left idle by itself");
  AST_RX_JUMP: assert property (
    cmd_wr && cmd_dir && cmd_op == cdj_pkg::OP_JUMP |=>
      st_reg[1] == cdj_pkg::ST_HEAD && !proc_en_o[1])
    else $error("receive jump not handled as activate");
  AST_TX_JUMP_HOLD: assert property (
    st_reg[0] == cdj_pkg::ST_JWAIT && !tx_msg_done_i && !cmd_wr |=>
      st_reg[0] == cdj_pkg::ST_JWAIT && proc_en_o[0])
    else $error("transmit jump ended before message done");
  AST_TX_JUMP_RUN: assert property (
    cmd_wr && !cmd_dir && cmd_op == cdj_pkg::OP_JUMP &&
    st_reg[0] == cdj_pkg::ST_RUN |=> ##1 (proc_en_o[0] && !abort_o[0]))
    else $error("transmit jump reset the channel");
  AST_HEAD_FIRST: assert property (
    st_reg[0] == cdj_pkg::ST_DESC |->
      $past(st_reg[0]) inside {cdj_pkg::ST_HEAD, cdj_pkg::ST_DESC})
    else $error("descriptor read without head read");
  AST_HDLC_NOW: assert property (
    st_reg[1] == cdj_pkg::ST_DESC && mem_ack_i[1] && mem_owner_i[1] &&
    !transp[1] && !(cmd_wr && cmd_dir) |=> st_reg[1] == cdj_pkg::ST_RUN)
    else $error("HDLC receive waited for alignment");
  AST_SLOT_START: assert property (
    st_reg[1] == cdj_pkg::ST_SLOT && !(cmd_wr && cmd_dir) ##1
    st_reg[1] == cdj_pkg::ST_RUN |->
      $past(fly_rx.cnt[2:0]) == 3'h0 &&
      ($past(fly_rx.cnt[CW-1:3]) != '0 || map_reg[31:1] == '0))
    else $error("stream started off its first slot");

  COV_DEACT: cover property (service_ack_descriptor_o &&
    service_ack_descriptor_op_o == cdj_pkg::OP_DEACTIVATE);
  COV_TX_JUMP: cover property (service_ack_descriptor_o &&
    service_ack_descriptor_op_o == cdj_pkg::OP_JUMP && !service_ack_descriptor_dir_o);
  COV_ALIGNED: cover property (st_reg[1] == cdj_pkg::ST_SLOT ##1
    st_reg[1] == cdj_pkg::ST_RUN);
endmodule : cdj_top

// [tb/cdj_mem_model.sv]
`timescale 1ns/10ps
// Tx answers fast and rx slowly, so both fetch paths see wait states
module cdj_mem_model (
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic [1:0]       req_i,
  input  wire logic [1:0]       desc_i,
  input  wire logic [1:0][31:0] addr_i,
  output logic      [1:0]       ack_o,
  output logic      [1:0]       own_o,
  output logic      [1:0][31:0] data_o
);
  logic [1:0][3:0] cnt_reg;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i)
      {cnt_reg, ack_o, own_o, data_o} <= '0;
    else begin
      for (int d = 0; d < 2; d++) begin
        if (req_i[d] && cnt_reg[d] == 4'(3 * d + 1)) begin
          ack_o[d]   <= 1'b1;
          cnt_reg[d] <= 4'h0;
          own_o[d]   <= desc_i[d];
          data_o[d]  <= addr_i[d] + 32'h0000_0040;
        end else begin
          ack_o[d]   <= 1'b0;
          cnt_reg[d] <= req_i[d] ? cnt_reg[d] + 4'h1 : 4'h0;
          // Stale data must not look valid between answers
          data_o[d]  <= ~data_o[d];
        end
      end
    end
  end
endmodule : cdj_mem_model

// [tb/test_channel_deactivate_jump_frame_align.sv]
`timescale 1ns/10ps
module test_channel_deactivate_jump_frame_align;
  logic             clock_i = '0, nrst_i = '0, reg_wr_i = '0, reg_rd_i = '0;
  logic             tx_clk_i = '0, tx_frame_sync_i = '0, tx_bit_i = '0;
  logic             tx_msg_done_i = '0, rd_d = '0, tx_serial_data_o;
  logic             tx_serial_data_oe_o, service_ack_descriptor_o, service_ack_descriptor_dir_o;
  logic [1:0]       proc_en_o, dma_en_o, abort_o, mem_req_o, mem_desc_o;
  logic [1:0]       mem_ack_i, mem_owner_i, service_ack_descriptor_op_o;
  logic [3:0]       reg_addr_i = '0;
  logic [31:0]      reg_wdata_i = '0, reg_rdata_o, h, seed = 32'h0000_055F;
  logic [1:0][31:0] mem_addr_o, mem_rdata_i;
  logic [31:0]      rq[$];
  logic [2:0]       sq[$];
  int               n_mismatch = 0, checked = 0, n_abort = 0;
  cdj_top #(.FRAME_BITS(16)) uut (.clock_i, .nrst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .tx_clk_i,
    .rx_clk_i(tx_clk_i), .tx_frame_sync_i, .rx_frame_sync_i(tx_frame_sync_i),
    .tx_bit_i, .tx_msg_done_i, .tx_serial_data_o, .tx_serial_data_oe_o,
    .proc_en_o, .dma_en_o, .abort_o, .mem_req_o, .mem_desc_o, .mem_addr_o,
    .mem_ack_i, .mem_owner_i, .mem_rdata_i, .service_ack_descriptor_o,
    .service_ack_descriptor_dir_o, .service_ack_descriptor_op_o);
  cdj_mem_model mem (.clock_i, .nrst_i, .req_i(mem_req_o), .desc_i(mem_desc_o),
    .addr_i(mem_addr_o), .ack_o(mem_ack_i), .own_o(mem_owner_i),
    .data_o(mem_rdata_i));
  initial forever #5 clock_i = ~clock_i;
  // Framer bit clock runs free; sync pins are shared by both directions
  initial forever #62.5 tx_clk_i = ~tx_clk_i;
  initial begin
    #200_000;
    n_mismatch++;
    conclude();
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic put(input logic [3:0] a, input logic [31:0] d, input logic r);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= !r;
    reg_rd_i    <= r;
    @(posedge clock_i);
    reg_wr_i    <= 1'b0;
    reg_rd_i    <= 1'b0;
  endtask : put
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    put(a, 32'h0000_0000, 1'b1);
  endtask : rd
  task automatic svc(input logic [1:0] op, input logic dir);
    sq.push_back({dir, op});
    put(cdj_pkg::REG_CMD, {29'h0000_0000, dir, op}, 1'b0);
  endtask : svc
  task automatic drain();
    for (int i = 0; i < 3000 && sq.size() != 0; i++) @(posedge clock_i);
    repeat (3) @(posedge clock_i);
    chk(sq.size() == 0, "ack missing");
  endtask : drain
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  always @(posedge clock_i) begin
    rd_d <= reg_rd_i;
    if (rd_d)
      chk(reg_rdata_o === rq.pop_front(), "read data");
    // An ack with nothing pending is itself a fault
    if (service_ack_descriptor_o !== 1'b0)
      chk(sq.size() != 0 &&
          {service_ack_descriptor_dir_o, service_ack_descriptor_op_o} === sq.pop_front(), "ack");
    if (abort_o !== 2'b00)
      n_abort++;
  end
  initial begin
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    rd(cdj_pkg::REG_STATUS, 32'h0000_0000);
    rd(4'hF, 32'h0000_0000);
    h = rnd();
    put(cdj_pkg::REG_TX_HEAD, h, 1'b0);
    rd(cdj_pkg::REG_TX_HEAD, h);
    put(cdj_pkg::REG_SLOT_MAP, 32'h0000_0003, 1'b0);
    for (int t = 0; t < 2; t++) begin
      put(cdj_pkg::REG_CFG, 32'(t), 1'b0);
      svc(cdj_pkg::OP_ACTIVATE, 1'b0);
      drain();
      tx_bit_i <= h[t];
      repeat (3) @(posedge clock_i);
      chk(dma_en_o[0] === 1'b1 && tx_serial_data_o === h[t], "hdlc");
      svc(cdj_pkg::OP_DEACTIVATE, 1'b0);
      drain();
      chk(proc_en_o[0] === 1'b0 && dma_en_o[0] === 1'b0, "tx stop");
      chk(tx_serial_data_oe_o === (t == 0) && tx_serial_data_o === 1'b1, "pin");
      rd(cdj_pkg::REG_CFG, 32'(t));
    end
    $display("test deactivate done");
    svc(cdj_pkg::OP_ACTIVATE, 1'b0);
    drain();
    svc(cdj_pkg::OP_JUMP, 1'b0);
    repeat (40) @(posedge clock_i);
    chk(sq.size() == 1 && proc_en_o[0] === 1'b1, "jump early");
    tx_msg_done_i <= 1'b1;
    @(posedge clock_i);
    tx_msg_done_i <= 1'b0;
    drain();
    chk(proc_en_o[0] === 1'b1, "jump state");
    svc(cdj_pkg::OP_JUMP, 1'b1);
    drain();
    chk(proc_en_o[1] === 1'b1, "rx jump");
    svc(cdj_pkg::OP_DEACTIVATE, 1'b0);
    svc(cdj_pkg::OP_DEACTIVATE, 1'b1);
    drain();
    chk(proc_en_o === 2'b00 && dma_en_o === 2'b00, "both stop");
    $display("test jump done");
    put(cdj_pkg::REG_CFG, 32'h0000_0010, 1'b0);
    svc(cdj_pkg::OP_ACTIVATE, 1'b1);
    drain();
    repeat (300) @(posedge clock_i);
    chk(dma_en_o[1] === 1'b0, "no sync yet");
    tx_frame_sync_i <= 1'b1;
    repeat (30) @(posedge clock_i);
    tx_frame_sync_i <= 1'b0;
    for (int i = 0; i < 2000 && dma_en_o[1] !== 1'b1; i++) @(posedge clock_i);
    chk(dma_en_o[1] === 1'b1, "aligned start");
    $display("test align done");
    svc(cdj_pkg::OP_DEACTIVATE, 1'b1);
    drain();
    put(cdj_pkg::REG_CFG, 32'h0000_0012, 1'b0);
    svc(cdj_pkg::OP_ACTIVATE, 1'b1);
    drain();
    // Flywheel frames keep coming but must not start the stream
    repeat (600) @(posedge clock_i);
    chk(dma_en_o[1] === 1'b0, "flywheel ignored");
    tx_frame_sync_i <= 1'b1;
    repeat (30) @(posedge clock_i);
    tx_frame_sync_i <= 1'b0;
    for (int i = 0; i < 2000 && dma_en_o[1] !== 1'b1; i++) @(posedge clock_i);
    chk(dma_en_o[1] === 1'b1, "external start");
    chk(n_abort == 5, "abort count");
    $display("test external align done");
    conclude();
  end
endmodule : test_channel_deactivate_jump_frame_align
